// File: rtl/srfi_pkg.sv
/*
 Constants and types for the safety relay fault indicator block.
 Assumes a single 25 MHz clock and a synchronous active-high reset.
*/
// Overview of operation
// RULE1 - Link output self-test failure faults the device with five red flashes.
// RULE2 - Only the solid-state variant tests its output pair; failure gives six flashes.
// RULE3 - Output-test faults latch until power is cycled.
// RULE4 - Switch change while running: keep running, green plus two flashes until restored.
// RULE5 - Power-up mismatch with stored setting: flash twice, no run; match runs green.
// RULE6 - Late jumper check happens only on output energization.
// RULE7 - Late jumper shows green plus three flashes, clears when removed.
// RULE8 - Non-retriggerable input re-on before expiry flags fault; clears on cycle or expiry.
// RULE9 - Old firmware maps late jumper to mismatch indication; new firmware ignores it.
// RULE10 - No or incomplete stored configuration stays in config mode, single flashes.
// RULE11 - Bursts repeat with a longer dark pause between bursts than between flashes.
package srfi_pkg;

  localparam int CLK_HZ        = 25_000_000;
  localparam int FLASH_ON_MS   = 200;
  localparam int FLASH_OFF_MS  = 200;
  localparam int BURST_GAP_MS  = 1200;
  localparam int FLASH_ON_CYC  = (CLK_HZ / 1000) * FLASH_ON_MS;
  localparam int FLASH_OFF_CYC = (CLK_HZ / 1000) * FLASH_OFF_MS;
  localparam int BURST_GAP_CYC = (CLK_HZ / 1000) * BURST_GAP_MS;

  localparam logic [2:0] FLASH_CFG     = 3'h1;
  localparam logic [2:0] FLASH_SWITCH  = 3'h2;
  localparam logic [2:0] FLASH_JUMPER  = 3'h3;
  localparam logic [2:0] FLASH_RETRIG  = 3'h4;
  localparam logic [2:0] FLASH_LINK    = 3'h5;
  localparam logic [2:0] FLASH_PAIR    = 3'h6;

  typedef enum logic [1:0] {SRFI_CHECK, SRFI_CONFIG, SRFI_RUN, SRFI_HALT} srfi_mode_t;
  typedef enum logic [1:0] {SRFI_IDLE, SRFI_ON, SRFI_OFF, SRFI_GAP} srfi_blink_t;

endpackage

// File: rtl/srfi_top.sv
/*
 Fault supervision and indicator encoding for a configurable safety relay.
 Assumes all inputs synchronous to mclk_in; srst_in stands in for power-on.
*/
`timescale 1ns/1ps
module srfi_top
  import srfi_pkg::*;
#(
  parameter int SW_W      = 8,
  parameter int ON_CYC    = FLASH_ON_CYC,
  parameter int OFF_CYC   = FLASH_OFF_CYC,
  parameter int GAP_CYC   = BURST_GAP_CYC
) (
  // Clock and reset
  input  wire logic            mclk_in,
  input  wire logic            srst_in,
  // Configuration sources
  input  wire logic [SW_W-1:0] switch_in,
  input  wire logic [SW_W-1:0] stored_cfg_in,
  input  wire logic            cfg_valid_in,
  input  wire logic            solid_state_variant_in,
  input  wire logic            fw_late_rev_in,
  // Output test results, one-cycle pulses
  input  wire logic            link_test_fail_in,
  input  wire logic            pair_test_fail_in,
  // Expansion module
  input  wire logic            jumper_bridged_in,
  input  wire logic            output_energize_in,
  input  wire logic            nonretrig_mode_in,
  input  wire logic            logic_in,
  input  wire logic            timer_running_in,
  // Indicator and status
  output logic                 green_out,
  output logic                 red_out,
  output logic                 run_out,
  output logic                 latched_fault_out
);

  srfi_mode_t       mode_ff, nxt_mode;
  srfi_blink_t      blink_ff, nxt_blink;
  logic [SW_W-1:0]  sw_ref_ff;
  logic [2:0]       link_pair_ff;     // [0] link, [1] pair
  logic             jumper_ff, retrig_ff, logic_d_ff, energ_d_ff, armed_ff;
  logic [31:0]      tmr_ff, nxt_tmr;
  logic [2:0]       cnt_ff, nxt_cnt;
  logic             green_ff, red_ff, run_ff, latch_ff;

  // Event decode
  // Only meaningful once running; the reference is still empty while checking
  wire sw_moved     = (mode_ff == SRFI_RUN) & (switch_in != sw_ref_ff);
  wire energ_rise   = output_energize_in & ~energ_d_ff;
  wire logic_rise   = logic_in & ~logic_d_ff;
  wire link_fail    = link_test_fail_in;                                // [RULE1]
  wire pair_fail    = pair_test_fail_in & solid_state_variant_in;      // [RULE2]
  wire late_jump_sw = jumper_ff & ~fw_late_rev_in;                      // [RULE9]

  // Burst selection: halting faults first, then green-with-red warnings
  wire [2:0] code =
      (mode_ff == SRFI_CONFIG)        ? FLASH_CFG    :                 // [RULE10]
      link_pair_ff[1]                 ? FLASH_PAIR   :
      link_pair_ff[0]                 ? FLASH_LINK   :
      (mode_ff == SRFI_HALT)          ? FLASH_SWITCH :                 // [RULE5]
      (sw_moved | late_jump_sw)       ? FLASH_SWITCH :                 // [RULE4]
      jumper_ff                       ? FLASH_JUMPER :                 // [RULE7]
      retrig_ff                       ? FLASH_RETRIG : 3'h0;           // [RULE8]
  wire green_on = (mode_ff == SRFI_RUN) & ~(|link_pair_ff);

  // Mode sequencing after power-up
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      SRFI_CHECK: begin
        if (!cfg_valid_in) begin
          nxt_mode = SRFI_CONFIG;                                      // [RULE10]
        end else if (switch_in != stored_cfg_in) begin
          nxt_mode = SRFI_HALT;                                        // [RULE5]
        end else begin
          nxt_mode = SRFI_RUN;
        end
      end
      SRFI_CONFIG: nxt_mode = SRFI_CONFIG;
      SRFI_RUN:    nxt_mode = SRFI_RUN;
      SRFI_HALT:   nxt_mode = SRFI_HALT;
    endcase
  end

  // Blink sequencer; long gap separates bursts
  always_comb begin
    nxt_blink = blink_ff;
    nxt_tmr   = tmr_ff - 32'h1;
    nxt_cnt   = cnt_ff;
    unique case (blink_ff)
      SRFI_IDLE: begin
        nxt_tmr = 32'h0;
        if (code != 3'h0) begin
          nxt_blink = SRFI_ON;
          nxt_tmr   = 32'(ON_CYC - 1);
          nxt_cnt   = code - 3'h1;
        end
      end
      SRFI_ON: begin
        if (tmr_ff == 32'h0) begin
          nxt_blink = (cnt_ff == 3'h0) ? SRFI_GAP : SRFI_OFF;
          nxt_tmr   = (cnt_ff == 3'h0) ? 32'(GAP_CYC - 1) : 32'(OFF_CYC - 1); // [RULE11]
        end
      end
      SRFI_OFF: begin
        if (tmr_ff == 32'h0) begin
          nxt_blink = SRFI_ON;
          nxt_tmr   = 32'(ON_CYC - 1);
          nxt_cnt   = cnt_ff - 3'h1;
        end
      end
      SRFI_GAP: begin
        if (tmr_ff == 32'h0) begin
          nxt_blink = SRFI_IDLE;                                       // [RULE11]
        end
      end
    endcase
  end

  // State and outputs
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      mode_ff      <= SRFI_CHECK;
      blink_ff     <= SRFI_IDLE;
      tmr_ff       <= 32'h0;
      cnt_ff       <= 3'h0;
      sw_ref_ff    <= {SW_W{1'b0}};
      link_pair_ff <= 3'h0;
      jumper_ff    <= 1'b0;
      retrig_ff    <= 1'b0;
      logic_d_ff   <= 1'b0;
      energ_d_ff   <= 1'b0;
      armed_ff     <= 1'b0;
      green_ff     <= 1'b0;
      red_ff       <= 1'b0;
      run_ff       <= 1'b0;
      latch_ff     <= 1'b0;
    end else begin
      mode_ff      <= nxt_mode;
      blink_ff     <= nxt_blink;
      tmr_ff       <= nxt_tmr;
      cnt_ff       <= nxt_cnt;
      // Power-up switch setting is the reference for later changes
      if (mode_ff == SRFI_CHECK) begin
        sw_ref_ff <= switch_in;                                       // [RULE4]
      end
      // Only reset (power cycle) clears these
      link_pair_ff <= link_pair_ff | {1'b0, pair_fail, link_fail};   // [RULE3]
      energ_d_ff   <= output_energize_in;
      logic_d_ff   <= logic_in;
      if (energ_rise) begin
        jumper_ff <= jumper_bridged_in;                               // [RULE6]
      end else if (!jumper_bridged_in) begin
        jumper_ff <= 1'b0;                                            // [RULE7]
      end
      // Armed while a non-retriggerable timing cycle runs
      armed_ff <= timer_running_in & nonretrig_mode_in;
      if (logic_rise && armed_ff && !retrig_ff) begin
        retrig_ff <= 1'b1;                                            // [RULE8]
      end else if (retrig_ff && (logic_rise || !timer_running_in)) begin
        retrig_ff <= 1'b0;                                            // [RULE8]
      end
      green_ff <= green_on;
      red_ff   <= (nxt_blink == SRFI_ON);
      run_ff   <= (nxt_mode == SRFI_RUN) & ~(|link_pair_ff) & ~link_fail & ~pair_fail;
      latch_ff <= |link_pair_ff;
    end
  end

  assign green_out         = green_ff;
  assign red_out           = red_ff;
  assign run_out           = run_ff;
  assign latched_fault_out = latch_ff;

  // Checks
  a_link_fault_latch: assert property (@(posedge mclk_in) disable iff (srst_in)
    link_test_fail_in |=> ##2 latched_fault_out [*8]) // [RULE3]
    else $error("link fault did not latch");
  a_pair_gate_variant: assert property (@(posedge mclk_in) disable iff (srst_in)
    (pair_test_fail_in && !solid_state_variant_in && !latched_fault_out && !link_test_fail_in)
      |=> !link_pair_ff[1]) // [RULE2]
    else $error("pair fault taken on wrong variant");
  a_fault_stops_run: assert property (@(posedge mclk_in) disable iff (srst_in)
    link_test_fail_in |=> !run_out) // [RULE1]
    else $error("device ran with link fault");
  a_mismatch_halts: assert property (@(posedge mclk_in) disable iff (srst_in)
    (mode_ff == SRFI_CHECK && cfg_valid_in && switch_in != stored_cfg_in) |=> ##1 !run_out [*4]) // [RULE5]
    else $error("ran despite mismatch");
  a_config_no_green: assert property (@(posedge mclk_in) disable iff (srst_in)
    (mode_ff == SRFI_CONFIG) |=> !green_out) // [RULE10]
    else $error("green in config mode");
  a_jumper_on_energize: assert property (@(posedge mclk_in) disable iff (srst_in)
    (!jumper_ff && !energ_rise) |=> !jumper_ff) // [RULE6]
    else $error("jumper fault without energization");
  a_jumper_clears: assert property (@(posedge mclk_in) disable iff (srst_in)
    (jumper_ff && !jumper_bridged_in && !energ_rise) |=> !jumper_ff) // [RULE7]
    else $error("jumper fault did not clear");
  a_retrig_clears: assert property (@(posedge mclk_in) disable iff (srst_in)
    (retrig_ff && !timer_running_in) |=> !retrig_ff) // [RULE8]
    else $error("retrigger fault held past expiry");
  a_gap_dark: assert property (@(posedge mclk_in) disable iff (srst_in)
    $rose(blink_ff == SRFI_GAP) |-> !red_out [*8]) // [RULE11]
    else $error("red lit during burst gap");
  a_switch_keeps_run: assert property (@(posedge mclk_in) disable iff (srst_in)
    (mode_ff == SRFI_RUN && sw_moved && !(|link_pair_ff) && !link_fail && !pair_fail)
      |=> run_out && green_out) // [RULE4]
    else $error("switch change stopped operation");
  a_late_rev_ignore: assert property (@(posedge mclk_in) disable iff (srst_in)
    (fw_late_rev_in && !sw_moved && mode_ff == SRFI_RUN && !(|link_pair_ff) && jumper_ff)
      |-> code == FLASH_JUMPER) // [RULE9]
    else $error("late revision showed mismatch for jumper");
  a_early_rev_map: assert property (@(posedge mclk_in) disable iff (srst_in)
    (!fw_late_rev_in && mode_ff == SRFI_RUN && !(|link_pair_ff) && jumper_ff)
      |-> code == FLASH_SWITCH) // [RULE9]
    else $error("early revision did not show mismatch for jumper");
  a_config_code: assert property (@(posedge mclk_in) disable iff (srst_in)
    (mode_ff == SRFI_CONFIG) |-> code == FLASH_CFG) // [RULE10]
    else $error("config mode not shown as single flash");
  a_halt_no_run: assert property (@(posedge mclk_in) disable iff (srst_in)
    (mode_ff == SRFI_HALT) |=> !run_out && !green_out) // [RULE5]
    else $error("halted device ran or showed green");

endmodule

// File: test/srfi_field.sv
/*
 Far-side wiring model: turns a short on the link or the output pair into a test-fail pulse.
 Assumes the bench raises the short requests just after a rising clock edge.
*/
`timescale 1ns/1ps
module srfi_field (
  // Clock
  input  wire logic clk_in,
  // Fault requests from the bench
  input  wire logic short_link_in,
  input  wire logic short_pair_in,
  // Output-test results to the relay
  output logic      link_fail_out,
  output logic      pair_fail_out
);
  logic link_q_ff;
  logic pair_q_ff;
  // Remember last request so a held short gives one pulse only
  always_ff @(posedge clk_in) begin
    link_q_ff <= short_link_in;
    pair_q_ff <= short_pair_in;
  end
  // Self-test fails once per new short
  assign link_fail_out = short_link_in & ~link_q_ff;
  assign pair_fail_out = short_pair_in & ~pair_q_ff;
endmodule

// File: test/srfi_top_tb.sv
/*
 Self-checking bench for the fault indicator: counts red flashes between long dark gaps.
 Assumes short flash timing parameters (3/3/10 cycles) and the srfi_field wiring model.
*/
`timescale 1ns/1ps
module srfi_top_tb;
  import srfi_pkg::*;
  logic       clk = 0, srst = 1, cfg_v = 0, ssv = 0, late = 1, jmp = 0, ener = 0;
  logic       nrt = 0, lgc = 0, tmr = 0, s_link = 0, s_pair = 0;
  logic [7:0] sw = 8'h00, stored = 8'h00;
  logic       lf, pf, green, red, run, latched;
  int         failures = 0, num_checks = 0, seed = 32'h20C40820;
  srfi_top #(.ON_CYC(3), .OFF_CYC(3), .GAP_CYC(10)) dut (.mclk_in(clk), .srst_in(srst),
    .switch_in(sw), .stored_cfg_in(stored), .cfg_valid_in(cfg_v), .solid_state_variant_in(ssv),
    .fw_late_rev_in(late), .link_test_fail_in(lf), .pair_test_fail_in(pf),
    .jumper_bridged_in(jmp), .output_energize_in(ener), .nonretrig_mode_in(nrt),
    .logic_in(lgc), .timer_running_in(tmr), .green_out(green), .red_out(red),
    .run_out(run), .latched_fault_out(latched));
  srfi_field field (.clk_in(clk), .short_link_in(s_link), .short_pair_in(s_pair),
    .link_fail_out(lf), .pair_fail_out(pf));
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  task report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask
  // Waits for a dark gap, then counts red rises up to the next gap
  task burst(input int n, input logic g, input logic r);
    int lo, cnt, k;
    logic pr;
    lo = 0; cnt = 0; pr = 0;
    for (k = 0; k < 300 && lo < 8; k++) begin
      @(posedge clk); lo = red ? 0 : lo + 1;
    end
    lo = 0;
    for (k = 0; k < 300 && lo < 8; k++) begin
      @(posedge clk); if (red && !pr) cnt++; pr = red; lo = red ? 0 : lo + 1;
    end
    chk(8'(cnt), 8'(n), "flashes");
    chk({7'h00, green}, {7'h00, g}, "green");
    chk({7'h00, run}, {7'h00, r}, "run");
  endtask
  task rst();
    srst <= 1;
    repeat (5) @(posedge clk);
    srst <= 0;
    repeat (3) @(posedge clk);
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Watchdog: all scenarios fit well inside this span
  initial begin
    #400us; failures++; report_and_stop();
  end
  initial begin
    sw = 8'($random(seed)); stored = sw;
    rst(); burst(1, 0, 0);
    cfg_v <= 1; rst(); burst(0, 1, 1);
    sw <= ~sw; burst(2, 1, 1);
    sw <= stored; burst(0, 1, 1);
    jmp <= 1; burst(0, 1, 1);
    ener <= 1; burst(3, 1, 1);
    late <= 0; burst(2, 1, 1);
    late <= 1; jmp <= 0; burst(0, 1, 1);
    nrt <= 1; tmr <= 1; lgc <= 1; step(2); lgc <= 0; step(2); lgc <= 1;
    burst(4, 1, 1);
    tmr <= 0; burst(0, 1, 1);
    s_pair <= 1; step(1); s_pair <= 0; burst(0, 1, 1);
    ssv <= 1; s_pair <= 1; step(1); s_pair <= 0; step(4);
    chk({7'h00, latched}, 8'h01, "latch");
    burst(6, 0, 0);
    burst(6, 0, 0);
    rst(); s_link <= 1; step(1); s_link <= 0; burst(5, 0, 0);
    chk({7'h00, latched}, 8'h01, "latch");
    stored <= sw ^ 8'h01; rst(); burst(2, 0, 0);
    report_and_stop();
  end
endmodule
